// *** src/ldc_ctrl_fault.sv ***
// module: control decode and laser safety fault logic
`timescale 1ns/1ns
module ldc_ctrl_fault #(
	parameter int LATCH_CYC  = ldc_pkg::LATCH_RESET_CYC,
	parameter int NEGATE_CYC = ldc_pkg::NEGATE_CYC
) (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic [7:0]          control_reg,
	input  wire logic [9:0]          modulation_code,
	input  wire logic [9:0]          bias_code,
	input  wire logic [1:0]          crossing_range,
	input  wire logic [7:0]          equalizer_level_reg,
	input  wire logic [7:0]          crossing_adjust_reg,
	input  wire logic [7:0]          limiter_bias_reg,
	input  wire logic [7:0]          high_current_enable_reg,
	input  wire logic [7:0]          coupling_ratio,
	input  wire logic                shutdown_pin,
	input  wire logic                monitor_over_ref,
	input  wire logic                photo_over_150,
	output logic                     fault_pin,
	output logic                     outputs_on,
	output logic [17:0]              mod_current_na,
	output logic [27:0]              bias_current_q,
	output logic                     bias_open_loop,
	output logic [6:0]               mod_limit_ma,
	output ldc_pkg::ldc_analog_t     analog
);

	// ============================================================
	// state
	typedef struct packed {
		logic [1:0]          sd_sync;
		logic [1:0]          mon_sync;
		logic [1:0]          pd_sync;
		ldc_pkg::ldc_state_t st;
		logic [15:0]         cnt;
		logic [9:0]          prev_bias;
		logic                fault;
		logic [17:0]         mod_na;
		logic [27:0]         bias_q;
		logic                ol;
		logic [6:0]          lim;
		ldc_pkg::ldc_analog_t an;
	} ldc_regs_t;

	ldc_regs_t r;
	ldc_regs_t next_r;
	logic      shut;
	logic      cond;
	logic      drop;
	logic      en_det;
	logic [3:0] unit;

	always_comb begin
		next_r = r;
		next_r.sd_sync  = {r.sd_sync[0], shutdown_pin};
		next_r.mon_sync = {r.mon_sync[0], monitor_over_ref};
		next_r.pd_sync  = {r.pd_sync[0], photo_over_150};
		// disabled by pin or cleared enable bit
		shut = r.sd_sync[1] | ~control_reg[ldc_pkg::CTRL_ENA];
		en_det = control_reg[ldc_pkg::CTRL_FLT];
		// new code below half of the previous one
		drop = ({1'b0, bias_code, 1'b0} < {2'b00, r.prev_bias})
			&& (bias_code != r.prev_bias);
		next_r.prev_bias = bias_code;
		cond = r.mon_sync[1] | r.pd_sync[1] | drop;
		case (r.st)
		ldc_pkg::LDC_RUN: begin
			next_r.cnt = 16'h0000;
			if (shut) begin
				next_r.st = ldc_pkg::LDC_OFF;
			end else if (en_det && cond) begin
				next_r.st    = ldc_pkg::LDC_FLT;
				next_r.fault = 1'b1;
			end
		end
		ldc_pkg::LDC_FLT: begin
			next_r.fault = 1'b1;
			if (shut) begin
				next_r.st    = ldc_pkg::LDC_OFF;
				next_r.fault = 1'b0;
				next_r.cnt   = 16'h0000;
			end
		end
		ldc_pkg::LDC_OFF: begin
			next_r.fault = 1'b0;
			if (shut) begin
				if (r.cnt != 16'hFFFF) begin
					next_r.cnt = r.cnt + 16'h0001;
				end
			end else if (r.cnt + 16'h0001 >= 16'(LATCH_CYC)) begin
				next_r.st  = ldc_pkg::LDC_WAIT;
				next_r.cnt = 16'h0000;
			end else begin
				next_r.cnt = 16'h0000;
			end
		end
		ldc_pkg::LDC_WAIT: begin
			if (shut) begin
				next_r.st  = ldc_pkg::LDC_OFF;
				next_r.cnt = 16'h0000;
			end else if (en_det && cond) begin
				next_r.st    = ldc_pkg::LDC_FLT;
				next_r.fault = 1'b1;
			end else if (r.cnt + 16'h0001 >= 16'(NEGATE_CYC)) begin
				next_r.st  = ldc_pkg::LDC_RUN;
				next_r.cnt = 16'h0000;
			end else begin
				next_r.cnt = r.cnt + 16'h0001;
			end
		end
		default: begin
			next_r.st = ldc_pkg::LDC_OFF;
		end
		endcase
		// decode of settings, registers themselves untouched
		// currents are zeroed in the register unless the next state runs
		next_r.mod_na = (next_r.st == ldc_pkg::LDC_RUN)
			? 18'(modulation_code) * ldc_pkg::MOD_STEP_NA
			: 18'h00000;
		next_r.ol = control_reg[ldc_pkg::CTRL_OL];
		case ({control_reg[ldc_pkg::CTRL_PR1], control_reg[ldc_pkg::CTRL_PR0]})
		ldc_pkg::PR_075: unit = ldc_pkg::UNIT_075_Q2;
		ldc_pkg::PR_150: unit = ldc_pkg::UNIT_150_Q2;
		default:         unit = ldc_pkg::UNIT_300_Q2;
		endcase
		if (next_r.st != ldc_pkg::LDC_RUN) begin
			next_r.bias_q = 28'h0000000;
		end else if (control_reg[ldc_pkg::CTRL_OL]) begin
			next_r.bias_q = 28'(18'(bias_code)
				* ldc_pkg::BIAS_OL_STEP_UA);
		end else begin
			next_r.bias_q = 28'(28'(unit) * 28'(coupling_ratio)
				* 28'(bias_code));
		end
		next_r.lim = high_current_enable_reg[0]
			? ldc_pkg::MOD_LIMIT_HI_MA : ldc_pkg::MOD_LIMIT_LO_MA;
		next_r.an.crossing_range = crossing_range;
		next_r.an.crossing_sign =
			crossing_adjust_reg[ldc_pkg::XS_SIGN];
		next_r.an.crossing_magnitude = crossing_adjust_reg[6:0];
		next_r.an.limiter_adjust_sign =
			limiter_bias_reg[ldc_pkg::LIM_SIGN];
		next_r.an.limiter_current_step = limiter_bias_reg[2:0];
		next_r.an.equalizer_on = control_reg[ldc_pkg::CTRL_EQ];
		// bypassed equalizer sees the weakest setting
		next_r.an.equalizer_level = control_reg[ldc_pkg::CTRL_EQ]
			? equalizer_level_reg : 8'hFF;
		next_r.an.high_mod_current_on = high_current_enable_reg[0];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
			r.st <= ldc_pkg::LDC_OFF;
			r.an.equalizer_level <= 8'hFF;
		end else begin
			r <= next_r;
		end
	end

	// ============================================================
	// outputs
	assign outputs_on     = (r.st == ldc_pkg::LDC_RUN);
	assign fault_pin      = r.fault;
	assign mod_current_na = r.mod_na;
	assign bias_current_q = r.bias_q;
	assign bias_open_loop = r.ol;
	assign mod_limit_ma   = r.lim;
	assign analog         = r.an;

	// ============================================================
	// assertions: fault handling
	AST_FLT_ZERO: assert property (
		@(posedge clk) disable iff (!resetn)
		fault_pin |-> mod_current_na == 18'h00000
		&& bias_current_q == 28'h0000000)
		else $error("outputs not zero during fault");

	AST_FLT_HOLD: assert property (
		@(posedge clk) disable iff (!resetn)
		fault_pin && !shut
		|=> fault_pin)
		else $error("fault not latched");

	AST_REL: assert property (
		@(posedge clk) disable iff (!resetn)
		shut
		|=> !fault_pin)
		else $error("fault pin not released");

	AST_OFF: assert property (
		@(posedge clk) disable iff (!resetn)
		$past(shut)
		|-> !outputs_on)
		else $error("running while disabled");

	AST_DET: assert property (
		@(posedge clk) disable iff (!resetn)
		r.st == ldc_pkg::LDC_RUN && !shut && en_det && cond
		|=> fault_pin)
		else $error("fault not detected");

	AST_NODET: assert property (
		@(posedge clk) disable iff (!resetn)
		!fault_pin && !en_det
		|=> !fault_pin)
		else $error("fault with detection off");

	AST_DROP: assert property (
		@(posedge clk) disable iff (!resetn)
		r.st == ldc_pkg::LDC_RUN && !shut && en_det && drop
		|=> fault_pin && !outputs_on)
		else $error("bias step drop not flagged");

	AST_PREV: assert property (
		@(posedge clk) disable iff (!resetn)
		1'b1
		|=> r.prev_bias == $past(bias_code))
		else $error("previous bias code not kept");

	AST_REFAULT: assert property (
		@(posedge clk) disable iff (!resetn)
		r.st == ldc_pkg::LDC_WAIT && !shut && en_det && cond
		|=> fault_pin && !outputs_on)
		else $error("persisting fault not flagged again");

	AST_LATCH: assert property (
		@(posedge clk) disable iff (!resetn)
		$past(r.st) == ldc_pkg::LDC_OFF && r.st == ldc_pkg::LDC_WAIT
		|-> $past(r.cnt) >= 16'(LATCH_CYC - 1))
		else $error("disable shorter than latch reset time");

	AST_RESUME: assert property (
		@(posedge clk) disable iff (!resetn)
		$past(r.st) == ldc_pkg::LDC_WAIT && r.st == ldc_pkg::LDC_RUN
		|-> $past(r.cnt) == 16'(NEGATE_CYC - 1))
		else $error("resumed before negate time");

	// ============================================================
	// assertions: decode of settings
	AST_EQ: assert property (
		@(posedge clk) disable iff (!resetn)
		!control_reg[ldc_pkg::CTRL_EQ]
		|=> analog.equalizer_level == 8'hFF && !analog.equalizer_on)
		else $error("equalizer not bypassed");

	AST_EQON: assert property (
		@(posedge clk) disable iff (!resetn)
		control_reg[ldc_pkg::CTRL_EQ]
		|=> analog.equalizer_on
		&& analog.equalizer_level == $past(equalizer_level_reg))
		else $error("equalizer level not passed");

	AST_LIM: assert property (
		@(posedge clk) disable iff (!resetn)
		high_current_enable_reg[0]
		|=> mod_limit_ma == ldc_pkg::MOD_LIMIT_HI_MA)
		else $error("high current limit wrong");

	AST_LIM_LO: assert property (
		@(posedge clk) disable iff (!resetn)
		!high_current_enable_reg[0]
		|=> mod_limit_ma == ldc_pkg::MOD_LIMIT_LO_MA)
		else $error("low current limit wrong");

	AST_MOD: assert property (
		@(posedge clk) disable iff (!resetn)
		outputs_on |-> mod_current_na
		== 18'($past(modulation_code)) * ldc_pkg::MOD_STEP_NA)
		else $error("modulation decode wrong");

	AST_OL: assert property (
		@(posedge clk) disable iff (!resetn)
		1'b1
		|=> bias_open_loop == $past(control_reg[ldc_pkg::CTRL_OL]))
		else $error("loop mode wrong");

	AST_BIAS_OL: assert property (
		@(posedge clk) disable iff (!resetn)
		outputs_on && bias_open_loop |-> bias_current_q
		== 28'($past(bias_code)) * 28'(ldc_pkg::BIAS_OL_STEP_UA))
		else $error("open loop bias wrong");

	AST_BIAS_CL: assert property (
		@(posedge clk) disable iff (!resetn)
		outputs_on && !bias_open_loop
		&& $past(control_reg[6:5]) == ldc_pkg::PR_075
		|-> bias_current_q == 28'(ldc_pkg::UNIT_075_Q2)
		* 28'($past(coupling_ratio)) * 28'($past(bias_code)))
		else $error("closed loop bias wrong");

	AST_RNG: assert property (
		@(posedge clk) disable iff (!resetn)
		1'b1
		|=> analog.crossing_range == $past(crossing_range))
		else $error("crossing range wrong");

	AST_XS: assert property (
		@(posedge clk) disable iff (!resetn)
		1'b1 |=> analog.crossing_sign
		== $past(crossing_adjust_reg[ldc_pkg::XS_SIGN])
		&& analog.crossing_magnitude == $past(crossing_adjust_reg[6:0]))
		else $error("crossing adjust wrong");

	AST_LIMB: assert property (
		@(posedge clk) disable iff (!resetn)
		1'b1 |=> analog.limiter_adjust_sign
		== $past(limiter_bias_reg[ldc_pkg::LIM_SIGN])
		&& analog.limiter_current_step == $past(limiter_bias_reg[2:0]))
		else $error("limiter adjust wrong");

	// ============================================================
	// covers
	COV_FAULT: cover property (@(posedge clk) disable iff (!resetn)
		$rose(fault_pin));
	COV_RECOVER: cover property (@(posedge clk) disable iff (!resetn)
		r.st == ldc_pkg::LDC_WAIT ##1 outputs_on);
	COV_REFAULT: cover property (@(posedge clk) disable iff (!resetn)
		r.st == ldc_pkg::LDC_WAIT ##1 r.st == ldc_pkg::LDC_FLT);
	COV_DROP: cover property (@(posedge clk) disable iff (!resetn)
		r.st == ldc_pkg::LDC_RUN && en_det && drop);
	COV_DETOFF: cover property (@(posedge clk) disable iff (!resetn)
		outputs_on && !en_det && r.mon_sync[1]);

endmodule

// *** src/ldc_pkg.sv ***
// package: constants and types of the laser driver control and fault block
// ============================================================
// Contract
// - crossing_range 00 gives smallest cross-point span, 11 the largest
// - ten-bit modulation_code sets current in 83 uA steps, 85 mA full
// - closed loop bias unit 0.75/1.5/3 uA by photo_range 00/01/1X
// - open loop bias equals 98 uA times bias_code
// - equalizer_on 0 bypasses equalizer and ignores equalizer_level
// - equalizer_level 00000000 strongest, 11111111 weakest equalization
// - crossing_sign 1 shifts crossing positive, 0 negative
// - crossing_magnitude 0000000 least shift, 1111111 most shift
// - limiter_adjust_sign 1 lowers limiter bias, 0 raises it
// - limiter_current_step 000 no change, 111 largest change
// - high_mod_current_on 0 limits to 80 mA, 1 extends to 100 mA
// - monitor above threshold reference flags a fault
// - photodiode current above 150 percent of set value flags a fault
// - bias code falling over 50 percent in one step flags a fault
// - enabled fault zeroes bias and modulation and latches fault_pin
// - fault_pin released while shutdown asserted or chip_enable clear
// - after disable removed and fault gone, resume prior settings (code resumes only after a disable held LATCH_CYC cycles, else stays off)
// - persisting fault re-asserts fault_pin after shutdown returns low
// - chip runs only while chip_enable bit 7 is 1
// - fault detection only when fault_detect_on bit 3 is 1
// - open_loop_select 1 open loop bias, 0 closed loop
// - equalizer_on 1 enables equalizer, 0 disables it
package ldc_pkg;

	// ============================================================
	// widths and fields
	localparam int CODE_W   = 10;
	localparam int CTRL_ENA = 7;
	localparam int CTRL_PR1 = 6;
	localparam int CTRL_PR0 = 5;
	localparam int CTRL_OL  = 4;
	localparam int CTRL_FLT = 3;
	localparam int CTRL_EQ  = 1;
	localparam int XS_SIGN  = 7;
	localparam int LIM_SIGN = 3;

	// ============================================================
	// reset values and figures
	localparam logic [7:0]  CTRL_RST   = 8'h80;
	localparam logic [7:0]  BYTE_RST   = 8'h00;
	localparam logic [9:0]  CODE_RST   = 10'h000;
	localparam logic [17:0] MOD_STEP_NA    = 18'h00053;
	localparam logic [17:0] BIAS_OL_STEP_UA = 18'h00062;
	localparam logic [1:0]  PR_075 = 2'h0;
	localparam logic [1:0]  PR_150 = 2'h1;
	localparam logic [3:0]  UNIT_075_Q2 = 4'h3;
	localparam logic [3:0]  UNIT_150_Q2 = 4'h6;
	localparam logic [3:0]  UNIT_300_Q2 = 4'hC;
	localparam logic [6:0]  MOD_LIMIT_LO_MA = 7'h50;
	localparam logic [6:0]  MOD_LIMIT_HI_MA = 7'h64;

	// ============================================================
	// timing
	localparam int CLK_NS          = 10;
	localparam int LATCH_RESET_NS  = 1000;
	localparam int NEGATE_NS       = 1000;
	localparam int LATCH_RESET_CYC =
		(LATCH_RESET_NS + CLK_NS - 1) / CLK_NS;
	localparam int NEGATE_CYC      =
		(NEGATE_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [3:0] {
		LDC_RUN  = 4'h1,
		LDC_OFF  = 4'h2,
		LDC_WAIT = 4'h4,
		LDC_FLT  = 4'h8
	} ldc_state_t;

	typedef struct packed {
		logic [1:0] crossing_range;
		logic       crossing_sign;
		logic [6:0] crossing_magnitude;
		logic       limiter_adjust_sign;
		logic [2:0] limiter_current_step;
		logic       equalizer_on;
		logic [7:0] equalizer_level;
		logic       high_mod_current_on;
	} ldc_analog_t;

endpackage

// *** test/ldc_ctrl_fault_tb_top.sv ***
// bench: control decode and fault recovery checks
`timescale 1ns/1ns
module ldc_ctrl_fault_tb_top;
	localparam int LC = 4;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        mon = 1'b0;
	logic        pho = 1'b0;
	logic [31:0] r = 32'h45A0AB01;
	logic [31:0] v;
	int          errors = 0;
	int          check_count = 0;
	logic        fp, on, ol, shut;
	logic [17:0] mi;
	logic [27:0] bi, keep;
	logic [6:0]  ml;
	logic [7:0]  ctrl, eq, xa, lim, hc, cr;
	logic [9:0]  mod, bias;
	logic [1:0]  rng;
	ldc_pkg::ldc_analog_t an;

	always #5 clk = ~clk;

	ldc_host host (.clk(clk), .ctrl(ctrl), .mod(mod), .bias(bias),
		.rng(rng), .eq(eq), .xa(xa), .lim(lim), .hc(hc), .cr(cr),
		.shut(shut));
	ldc_ctrl_fault #(.LATCH_CYC(LC), .NEGATE_CYC(4)) dut (
		.clk(clk), .resetn(resetn), .control_reg(ctrl),
		.modulation_code(mod), .bias_code(bias), .crossing_range(rng),
		.equalizer_level_reg(eq), .crossing_adjust_reg(xa),
		.limiter_bias_reg(lim), .high_current_enable_reg(hc),
		.coupling_ratio(cr), .shutdown_pin(shut),
		.monitor_over_ref(mon), .photo_over_150(pho), .fault_pin(fp),
		.outputs_on(on), .mod_current_na(mi), .bias_current_q(bi),
		.bias_open_loop(ol), .mod_limit_ma(ml), .analog(an));

	// ============================================================
	// helpers
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [27:0] exp_bias(input logic [7:0] c,
		input logic [7:0] k, input logic [9:0] b);
		if (c[4]) return 28'(b) * 28'h62;
		return 28'(k) * 28'(b) * (c[6] ? 28'hC : (c[5] ? 28'h6 : 28'h3));
	endfunction

	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string n, input logic [27:0] e,
		input logic [27:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %0h got %0h", n, e, g);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic recover(input logic by_pin);
		int i;
		host.clear_fault(LC + 2, by_pin);
		chk("released", 28'h0, 28'(fp));
		for (i = 0; i < 40 && on !== 1'b1; i++) tk(1);
		chk("running", 28'h1, 28'(on));
		if (on !== 1'b1) end_sim();
	endtask

	// ============================================================
	// main sequence
	initial begin
		tk(10);
		resetn = 1'b1;
		recover(1'b1);
		for (int i = 0; i < 40; i++) begin
			r = nx(r);
			v = (i == 0) ? 32'hFFFFFFFF : ((i == 1) ? 32'h0 : r);
			host.ctrl = (v[7:0] & 8'h72) | 8'h80;
			{host.mod, host.bias, host.rng, host.cr} = v[29:0];
			r = nx(r);
			v = (i == 0) ? 32'hFFFFFFFF : ((i == 1) ? 32'h0 : r);
			{host.eq, host.xa, host.lim, host.hc} = v;
			tk(2);
			chk("mod", 28'(mod) * 28'h53, 28'(mi));
			chk("bias", exp_bias(ctrl, cr, bias), bi);
			chk("open", 28'(ctrl[4]), 28'(ol));
			chk("limit", hc[0] ? 28'h64 : 28'h50, 28'(ml));
			chk("analog", 28'({rng, xa, lim[3:0], ctrl[1],
				ctrl[1] ? eq : 8'hFF, hc[0]}), 28'(an));
		end
		$display("test decode done");
		host.bias = 10'h100;
		tk(3);
		host.ctrl = 8'h88;
		tk(2);
		host.bias = 10'h080;
		tk(4);
		chk("half_drop", 28'h0, 28'(fp));
		host.bias = 10'h03F;
		tk(4);
		chk("big_drop", 28'h1, 28'(fp));
		recover(1'b0);
		$display("test drop done");
		keep = 28'(mi);
		mon = 1'b1;
		tk(4);
		chk("flt_mon", 28'h1, 28'(fp));
		chk("zero", 28'h0, 28'(mi) | bi | 28'(on));
		host.clear_fault(LC + 2, 1'b1);
		chk("released", 28'h0, 28'(fp));
		tk(6);
		chk("again", 28'h1, 28'(fp) | 28'(on) << 1);
		mon = 1'b0;
		recover(1'b0);
		chk("restore", keep, 28'(mi));
		pho = 1'b1;
		tk(4);
		chk("flt_photo", 28'h1, 28'(fp));
		pho = 1'b0;
		recover(1'b1);
		$display("test fault done");
		host.ctrl = 8'h80;
		mon = 1'b1;
		tk(5);
		chk("ignored", 28'h1, 28'(on) | 28'(fp) << 1);
		mon = 1'b0;
		$display("test detect_off done");
		end_sim();
	end
endmodule

// *** test/ldc_host.sv ***
// partner: controller model holding register bytes and the disable pin
`timescale 1ns/1ns
module ldc_host (
	input  wire logic clk,
	output logic [7:0] ctrl,
	output logic [9:0] mod,
	output logic [9:0] bias,
	output logic [1:0] rng,
	output logic [7:0] eq,
	output logic [7:0] xa,
	output logic [7:0] lim,
	output logic [7:0] hc,
	output logic [7:0] cr,
	output logic       shut
);
	// ============================================================
	// register bytes after power-up, chip enabled
	initial begin
		{mod, bias, rng, eq, xa, lim, hc, cr, shut} = '0;
		ctrl = 8'h80;
	end

	// ============================================================
	// disable by pin or enable bit, held n cycles, short or long
	task automatic clear_fault(input int n, input logic by_pin);
		if (by_pin) begin
			shut = 1'b1;
		end else begin
			ctrl[7] = 1'b0;
		end
		repeat (n) @(posedge clk);
		#1;
		shut = 1'b0;
		ctrl[7] = 1'b1;
	endtask
endmodule
